/* File: design/tcs_alert.sv */
// ram access alert pulse of selectable length
`timescale 1ns/1ns
`default_nettype none
module tcs_alert #(
  parameter int LONG_CYC  = tcs_pkg::ALERT_LONG_CYC,
  parameter int SHORT_CYC = tcs_pkg::ALERT_SHORT_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic long_sel,
  output logic      alert
);
  logic [8:0] cnt_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) cnt_reg <= 9'h000;
    else if (start) cnt_reg <= long_sel ? 9'(LONG_CYC) : 9'(SHORT_CYC);
    else if (cnt_reg != 9'h000) cnt_reg <= cnt_reg - 9'h001;
  end
  assign alert = (cnt_reg != 9'h000);
endmodule
`default_nettype wire

/* File: design/tcs_ctl_if.sv */
// control word carrier between the top and the status keeper
`timescale 1ns/1ns
`default_nettype none
interface tcs_ctl_if;
  logic [12:0] ctl;
  logic        rd_done;
  modport src (output ctl, output rd_done);
  modport dst (input ctl, input rd_done);
endinterface
`default_nettype wire

/* File: design/tcs_pkg.sv */
// constants for the terminal control and status register pair
package tcs_pkg;
  localparam int CTL_W           = 13;
  localparam int STS_W           = 16;
  localparam logic [12:0] CTL_RESET = 13'h1e0b;
  localparam int CB_BUS_A        = 0;
  localparam int CB_BUS_B        = 1;
  localparam int CB_TFLAG        = 2;
  localparam int CB_BUSY         = 3;
  localparam int CB_SUBSYS       = 4;
  localparam int CB_ST_PICK      = 5;
  localparam int CB_ST_ON        = 6;
  localparam int CB_SVC_REQ      = 7;
  localparam int CB_MEAS         = 8;
  localparam int CB_BCAST        = 9;
  localparam int CB_NOTICE       = 10;
  localparam int CB_PIN_SEL      = 11;
  localparam int CB_ALERT_LEN    = 12;
  localparam int SB_KIND         = 5;
  localparam int SB_LAST_BUS     = 6;
  localparam int SB_BUS_B        = 7;
  localparam int SB_BUS_A        = 8;
  localparam int SB_FLAG_OK      = 9;
  localparam int SB_BUSY         = 10;
  localparam int SB_SELFTEST     = 11;
  localparam int SB_PARITY       = 12;
  localparam int SB_MSG_FAULT    = 13;
  localparam int SB_GOOD_MSG     = 14;
  localparam int SB_ACTIVE       = 15;
  localparam int CLK_MHZ         = 25;
  localparam int SETUP_NS        = 50;
  localparam int SETUP_CYC       = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int ALERT_LONG_NS   = 5700;
  localparam int ALERT_SHORT_NS  = 2700;
  localparam int ALERT_LONG_CYC  = (ALERT_LONG_NS * CLK_MHZ) / 1000;
  localparam int ALERT_SHORT_CYC = (ALERT_SHORT_NS * CLK_MHZ) / 1000;
  typedef enum logic [1:0] {
    TCS_IDLE  = 2'b00,
    TCS_WRITE = 2'b01,
    TCS_READ  = 2'b10
  } tcs_acc_t;
endpackage

/* File: design/tcs_regs.sv */
// control and status register pair of the remote terminal host port
`timescale 1ns/1ns
`default_nettype none
module tcs_regs (
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire logic        SELECT_N,
  input  wire logic        CHIP_SELECT_N,
  input  wire logic        READ_WRITE,
  input  wire logic        OUT_ENABLE_N,
  input  wire logic [15:0] DATA_IN,
  output logic      [15:0] DATA_OUT,
  output logic             DATA_OE,
  input  wire logic [4:0]  CMD_FIELD,
  input  wire logic        CMD_IS_SA,
  input  wire logic        CMD_BUS_A,
  input  wire logic        CMD_VALID,
  input  wire logic        CMD_BROADCAST,
  input  wire logic        FLAG_INHIBIT_CMD,
  input  wire logic        FLAG_RESTORE_CMD,
  input  wire logic        PARITY_ERR,
  input  wire logic        MSG_ERR,
  input  wire logic        GOOD_MSG,
  input  wire logic        TRANSFER_IN_PROGRESS,
  input  wire logic        COMMAND_STROBE,
  input  wire logic        MEM_REQ,
  output logic             BUS_A_RX_EN,
  output logic             BUS_B_RX_EN,
  output logic             SELFTEST_ON,
  output logic             SELFTEST_CHANNEL_PICK,
  output logic             BROADCAST_HIT,
  output logic             NOTICE_THREE,
  output logic             DATA_MEM_EN,
  output logic             CMD_MEM_EN,
  output logic [3:0]       STATUS_FLAGS,
  output logic             STATUS_BUSY,
  output logic             DISCONNECT_OUT,
  output logic             TERMINAL_ACTIVE_OUT,
  output logic             RAM_ACCESS_ALERT
);
  tcs_ctl_if cif ();
  logic [12:0]  ctl_reg;
  logic [15:0]  status;
  logic [3:0]   flags_reg;
  logic         busy_reg;
  logic [15:0]  dout_reg;
  logic         rd_prev_reg;
  logic         parity_seen;
  tcs_pkg::tcs_acc_t acc;

  always_comb begin
    acc = tcs_pkg::TCS_IDLE;
    if (!SELECT_N && !CHIP_SELECT_N) begin
      if (OUT_ENABLE_N && !READ_WRITE) acc = tcs_pkg::TCS_WRITE;
      else if (!OUT_ENABLE_N && READ_WRITE) acc = tcs_pkg::TCS_READ;
    end
  end

  // control capture, no alert gating, top lines dropped
  always_ff @(posedge CLOCK) begin
    if (!RSTN) ctl_reg <= tcs_pkg::CTL_RESET;
    else if (acc == tcs_pkg::TCS_WRITE) ctl_reg <= DATA_IN[12:0];
  end

  // read data registered, driven while read strobes held
  always_ff @(posedge CLOCK) begin
    if (!RSTN) dout_reg <= 16'h0000;
    else dout_reg <= status;
  end
  assign DATA_OUT = dout_reg;
  assign DATA_OE  = (acc == tcs_pkg::TCS_READ);

  // clear sticky good-message and fault bits at end of a read
  always_ff @(posedge CLOCK) begin
    if (!RSTN) rd_prev_reg <= 1'b0;
    else rd_prev_reg <= (acc == tcs_pkg::TCS_READ);
  end
  assign cif.ctl     = ctl_reg;
  assign cif.rd_done = rd_prev_reg && (acc != tcs_pkg::TCS_READ);

  tcs_status u_status (
    .clk        (CLOCK),
    .rst_n      (RSTN),
    .cif        (cif),
    .cmd_field  (CMD_FIELD),
    .cmd_is_sa  (CMD_IS_SA),
    .cmd_bus_a  (CMD_BUS_A),
    .cmd_valid  (CMD_VALID),
    .flag_inhibit(FLAG_INHIBIT_CMD),
    .flag_restore(FLAG_RESTORE_CMD),
    .parity_err (PARITY_ERR),
    .msg_err    (MSG_ERR),
    .good_msg   (GOOD_MSG),
    .active     (TRANSFER_IN_PROGRESS),
    .status     (status)
  );
  assign parity_seen = status[tcs_pkg::SB_PARITY];

  // flags frozen at command strobe; setup time is the host's
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      flags_reg <= 4'h0;
      busy_reg  <= 1'b1;
    end else if (COMMAND_STROBE) begin
      flags_reg <= {ctl_reg[tcs_pkg::CB_MEAS], ctl_reg[tcs_pkg::CB_SVC_REQ],
                    ctl_reg[tcs_pkg::CB_SUBSYS],
                    ctl_reg[tcs_pkg::CB_TFLAG] & status[tcs_pkg::SB_FLAG_OK]};
      busy_reg  <= ctl_reg[tcs_pkg::CB_BUSY];
    end
  end
  assign STATUS_FLAGS = flags_reg;
  assign STATUS_BUSY  = busy_reg;

  // receivers off on parity fault or self-test
  assign BUS_A_RX_EN = ctl_reg[tcs_pkg::CB_BUS_A] & ~parity_seen & ~ctl_reg[tcs_pkg::CB_ST_ON];
  assign BUS_B_RX_EN = ctl_reg[tcs_pkg::CB_BUS_B] & ~parity_seen & ~ctl_reg[tcs_pkg::CB_ST_ON];
  assign SELFTEST_ON           = ctl_reg[tcs_pkg::CB_ST_ON];
  assign SELFTEST_CHANNEL_PICK = ctl_reg[tcs_pkg::CB_ST_PICK];
  assign BROADCAST_HIT = CMD_BROADCAST & ctl_reg[tcs_pkg::CB_BCAST];
  assign NOTICE_THREE  = ctl_reg[tcs_pkg::CB_NOTICE];
  assign DATA_MEM_EN   = ~ctl_reg[tcs_pkg::CB_BUSY];
  assign CMD_MEM_EN    = 1'b1;
  assign TERMINAL_ACTIVE_OUT = ctl_reg[tcs_pkg::CB_PIN_SEL] ? 1'b1 : ~TRANSFER_IN_PROGRESS;
  assign DISCONNECT_OUT      = ctl_reg[tcs_pkg::CB_PIN_SEL] ? ~(BUS_A_RX_EN | BUS_B_RX_EN)
                                                            : 1'b0;

  tcs_alert u_alert (
    .clk     (CLOCK),
    .rst_n   (RSTN),
    .start   (MEM_REQ),
    .long_sel(ctl_reg[tcs_pkg::CB_ALERT_LEN]),
    .alert   (RAM_ACCESS_ALERT)
  );
endmodule
`default_nettype wire

/* File: design/tcs_status.sv */
// status word keeper with sticky message flags
`timescale 1ns/1ns
`default_nettype none
module tcs_status (
  input  wire logic       clk,
  input  wire logic       rst_n,
  tcs_ctl_if.dst          cif,
  input  wire logic [4:0] cmd_field,
  input  wire logic       cmd_is_sa,
  input  wire logic       cmd_bus_a,
  input  wire logic       cmd_valid,
  input  wire logic       flag_inhibit,
  input  wire logic       flag_restore,
  input  wire logic       parity_err,
  input  wire logic       msg_err,
  input  wire logic       good_msg,
  input  wire logic       active,
  output logic [15:0]     status
);
  logic [5:0] field_reg;
  logic       bus_reg;
  logic       flag_allowed_reg;
  logic       parity_reg;
  logic       fault_reg;
  logic       good_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      field_reg <= 6'h00;
      bus_reg   <= 1'b1;
    end else if (cmd_valid) begin
      field_reg <= {cmd_is_sa, cmd_field};
      bus_reg   <= cmd_bus_a;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) flag_allowed_reg <= 1'b1;
    else if (flag_inhibit) flag_allowed_reg <= 1'b0;
    else if (flag_restore) flag_allowed_reg <= 1'b1;
  end

  // parity fault latch, cleared by reset only
  always_ff @(posedge clk) begin
    if (!rst_n) parity_reg <= 1'b0;
    else if (parity_err) parity_reg <= 1'b1;
  end

  // set wins; live cause keeps it set
  always_ff @(posedge clk) begin
    if (!rst_n) fault_reg <= 1'b0;
    else if (msg_err || parity_err || parity_reg) fault_reg <= 1'b1;
    else if (cif.rd_done) fault_reg <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) good_reg <= 1'b0;
    else if (good_msg) good_reg <= 1'b1;
    else if (cif.rd_done) good_reg <= 1'b0;
  end

  always_comb begin
    status = {active, good_reg, fault_reg, parity_reg,
              cif.ctl[tcs_pkg::CB_ST_ON], cif.ctl[tcs_pkg::CB_BUSY], flag_allowed_reg,
              cif.ctl[tcs_pkg::CB_BUS_A] & ~parity_reg,
              cif.ctl[tcs_pkg::CB_BUS_B] & ~parity_reg,
              bus_reg, field_reg};
  end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the control and status register pair
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic        clk, rstn, merr, tip, bc, a_en, b_en, pick, bhit, n3, ta, alert, cmem;
  logic  [6:0] ev, cmd;
  logic  [3:0] flags, stb;
  logic [15:0] din, dout, q, want;
  logic        doe;
  int          bad_count, comparisons, k;
  logic [15:0] cw [3] = '{16'hf5b4, 16'h0a48, 16'h1e0b};
  logic  [6:0] cv [3] = '{7'h35, 7'h40, 7'h5f};
  tcs_host host (.clk(clk), .dout(dout), .doe(doe), .stb(stb), .din(din));
  tcs_regs dut (.CLOCK(clk), .RSTN(rstn), .SELECT_N(stb[3]), .CHIP_SELECT_N(stb[2]),
    .READ_WRITE(stb[1]), .OUT_ENABLE_N(stb[0]), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe),
    .CMD_FIELD(cmd[4:0]), .CMD_IS_SA(cmd[5]), .CMD_BUS_A(cmd[6]), .CMD_VALID(ev[0]),
    .CMD_BROADCAST(bc), .FLAG_INHIBIT_CMD(ev[1]), .FLAG_RESTORE_CMD(ev[2]), .PARITY_ERR(ev[3]),
    .MSG_ERR(merr), .GOOD_MSG(ev[4]), .TRANSFER_IN_PROGRESS(tip), .COMMAND_STROBE(ev[5]),
    .MEM_REQ(ev[6]), .BUS_A_RX_EN(a_en), .BUS_B_RX_EN(b_en), .SELFTEST_ON(),
    .SELFTEST_CHANNEL_PICK(pick), .BROADCAST_HIT(bhit), .NOTICE_THREE(n3), .DATA_MEM_EN(),
    .CMD_MEM_EN(cmem), .STATUS_FLAGS(flags), .STATUS_BUSY(), .DISCONNECT_OUT(),
    .TERMINAL_ACTIVE_OUT(ta), .RAM_ACCESS_ALERT(alert));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [15:0] m, input logic [15:0] e);
    host.rd(q);
    `CHK(q & m, e)
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {rstn, merr, tip, bc, ev, cmd} = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(16'hffff, 16'h07c0);
    foreach (cv[i]) begin
      cmd <= cv[i];
      pulse(0);
      rd_chk(16'h007f, {9'h000, cv[i]});
    end
    $display("reset and command tests done");
    {tip, bc} <= 2'b11;
    foreach (cw[i]) begin
      host.wr(cw[i]);
      repeat (tcs_pkg::SETUP_CYC) @(posedge clk);
      pulse(5);
      `CHK(flags, {cw[i][8], cw[i][7], cw[i][4], cw[i][2]})
      `CHK({a_en, b_en, pick}, {cw[i][0], cw[i][1], cw[i][5]})
      `CHK({n3, bhit, ta, cmem}, {cw[i][10:9], cw[i][11], 1'b1})
      want = {4'h8, cw[i][6], cw[i][3], 1'b0, cw[i][0], cw[i][1], 7'h00};
      rd_chk(16'h8d80, want);
    end
    $display("control word tests done");
    pulse(1);
    host.wr(16'h0e0f);
    repeat (tcs_pkg::SETUP_CYC) @(posedge clk);
    pulse(5);
    `CHK(flags[0], 1'b0)
    rd_chk(16'h0200, 16'h0000);
    pulse(2);
    rd_chk(16'h0200, 16'h0200);
    pulse(4);
    rd_chk(16'h4000, 16'h4000);
    rd_chk(16'h4000, 16'h0000);
    merr <= 1'b1;
    rd_chk(16'h2000, 16'h2000);
    rd_chk(16'h2000, 16'h2000);
    // hold the fault over the clearing edge of the last read
    @(posedge clk);
    merr <= 1'b0;
    rd_chk(16'h2000, 16'h2000);
    rd_chk(16'h2000, 16'h0000);
    $display("flag tests done");
    for (int j = 1; j >= 0; j--) begin
      host.wr({3'h0, j[0], 12'he0b});
      pulse(6);
      k = 0;
      while (alert === 1'b1 && k < 400) begin
        @(posedge clk);
        #1;
        k++;
      end
      `CHK(k, j ? tcs_pkg::ALERT_LONG_CYC : tcs_pkg::ALERT_SHORT_CYC)
    end
    pulse(6);
    rd_chk(16'h0400, 16'h0400);
    `CHK(alert, 1'b1)
    pulse(3);
    rd_chk(16'h3180, 16'h3000);
    $display("alert and parity tests done");
    end_sim();
  end
endmodule
`default_nettype wire

/* File: test/tcs_host.sv */
// host processor model on the register strobes
`timescale 1ns/1ns
`default_nettype none
module tcs_host (
  input  wire logic        clk,
  input  wire logic [15:0] dout,
  input  wire logic        doe,
  output logic       [3:0] stb,
  output logic      [15:0] din
);
  initial begin
    stb = 4'hf;
    din = 16'h0000;
  end
  // strobes held one edge; data then inverted, not left
  task automatic wr(input logic [15:0] d);
    @(posedge clk);
    stb <= 4'h1;
    din <= d;
    @(posedge clk);
    stb <= 4'hf;
    din <= ~d;
  endtask
  // word taken at second edge, only if driven
  task automatic rd(output logic [15:0] q);
    @(posedge clk);
    stb <= 4'h2;
    repeat (2) @(posedge clk);
    q = doe ? dout : 16'hxxxx;
    stb <= 4'hf;
  endtask
endmodule
`default_nettype wire

/* File: test/tcs_monitor.sv */
// checker for the control and status register pair
`timescale 1ns/1ns
`default_nettype none
module tcs_monitor (
  input wire logic        CLOCK,
  input wire logic        RSTN,
  input wire logic        SELECT_N,
  input wire logic        CHIP_SELECT_N,
  input wire logic        READ_WRITE,
  input wire logic        OUT_ENABLE_N,
  input wire logic [15:0] DATA_IN,
  input wire logic        DATA_OE,
  input wire logic        CMD_BROADCAST,
  input wire logic        PARITY_ERR,
  input wire logic        COMMAND_STROBE,
  input wire logic        MEM_REQ,
  input wire logic        BUS_A_RX_EN,
  input wire logic        BUS_B_RX_EN,
  input wire logic        SELFTEST_ON,
  input wire logic        BROADCAST_HIT,
  input wire logic        DATA_MEM_EN,
  input wire logic [3:0]  STATUS_FLAGS,
  input wire logic        STATUS_BUSY,
  input wire logic        DISCONNECT_OUT,
  input wire logic        RAM_ACCESS_ALERT
);
  logic [12:0] ctl_reg;
  logic        rx_off;
  assign rx_off = !BUS_A_RX_EN && !BUS_B_RX_EN;
  // shadow of the write-only word, the design shows only bits 6, 3, 1 and 0 of it in the status word
  always_ff @(posedge CLOCK) begin
    if (!RSTN) ctl_reg <= tcs_pkg::CTL_RESET;
    else if (!SELECT_N && !CHIP_SELECT_N && !READ_WRITE && OUT_ENABLE_N) ctl_reg <= DATA_IN[12:0];
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  a_read_drive: assert property (
    DATA_OE == (!SELECT_N && !CHIP_SELECT_N && !OUT_ENABLE_N && READ_WRITE)) else $error("oe");
  a_bcast_gate: assert property (
    BROADCAST_HIT == (CMD_BROADCAST && ctl_reg[9])) else $error("broadcast");
  a_selftest_rx: assert property (
    SELFTEST_ON == ctl_reg[6] && (!SELFTEST_ON || rx_off)) else $error("selftest");
  a_busy_mem: assert property (DATA_MEM_EN == !ctl_reg[3]) else $error("busy");
  a_parity_off: assert property (PARITY_ERR |=> rx_off) else $error("parity");
  a_flag_copy: assert property (
    COMMAND_STROBE |=> STATUS_FLAGS[3] == $past(ctl_reg[8]) && STATUS_FLAGS[2] == $past(ctl_reg[7])
    && STATUS_FLAGS[1] == $past(ctl_reg[4]) && STATUS_BUSY == $past(ctl_reg[3])) else $error("flags");
  a_pin_disc: assert property (
    DISCONNECT_OUT == (ctl_reg[11] && rx_off)) else $error("disconnect");
  a_alert_long: assert property (
    MEM_REQ && !RAM_ACCESS_ALERT && ctl_reg[12] |=> RAM_ACCESS_ALERT [*8] ##134 RAM_ACCESS_ALERT
    ##1 !RAM_ACCESS_ALERT) else $error("long alert");
  a_alert_short: assert property (
    MEM_REQ && !RAM_ACCESS_ALERT && !ctl_reg[12] |=> RAM_ACCESS_ALERT [*8] ##59 RAM_ACCESS_ALERT
    ##1 !RAM_ACCESS_ALERT) else $error("short alert");
endmodule
bind tcs_regs tcs_monitor u_mon (.CLOCK, .RSTN, .SELECT_N, .CHIP_SELECT_N, .READ_WRITE,
  .OUT_ENABLE_N, .DATA_IN, .DATA_OE, .CMD_BROADCAST, .PARITY_ERR, .COMMAND_STROBE, .MEM_REQ,
  .BUS_A_RX_EN, .BUS_B_RX_EN, .SELFTEST_ON, .BROADCAST_HIT, .DATA_MEM_EN, .STATUS_FLAGS,
  .STATUS_BUSY, .DISCONNECT_OUT, .RAM_ACCESS_ALERT);
`default_nettype wire
